/* src/gtir_top.sv */
// Purpose: pin control, pin status and timing interrupt register bank
// Assumes: MDIO/SPI front end presents decoded single-cycle accesses
// Notes: answers one cycle after the access; reads clear latched flags
// Function
// - serial port off moves timing bank to MDIO
// - two-bit bank field picks MDIO 16-21 set
// - ident register read-only: step and part code
// - control bit 15 resets device, self clears
// - two output pin modes, reset to 110
// - pin1 mode strap: clock output or off
// - general pin 2-7 modes reset to 000
// - upper pins edge select for latching
// - lower pins edge select for latching
// - pin latched flags set on edge, read clears
// - live pin levels shown without latching
// - summary bits for timing and PHY interrupts
// - stamp queue overflow flags latch until read
// - stamp queue filled flags latch until read
// - pulse queue has-room flags latch until read
// - pulse sequence done flags latch until read
// - marked pulse event done flags latch
// - time adjust done flag latches until read
// - per-bit timing interrupt enables, reset zero
// - enabled flag drives interrupt toward pins
`timescale 1ns/1ps
`default_nettype none
module gtir_top #(
  parameter logic [3:0] SILICON_STEP = 4'h1, // arbitrary value
  parameter logic [11:0] PART_CODE = 12'h5A3 // arbitrary value
)(
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register access from the management front end
  input wire logic acc_valid_in,
  input wire logic acc_write_in,
  input wire logic acc_spi_in,
  input wire logic [gtir_pkg::ADDR_W-1:0] acc_addr_in,
  input wire logic [gtir_pkg::DATA_W-1:0] acc_wdata_in,
  output logic [gtir_pkg::DATA_W-1:0] rdata_out,
  output logic ack_out,
  // pins
  input wire logic [gtir_pkg::PIN_N-1:0] gpio_pin_in,
  input wire logic strap_mode_in,
  input wire logic out_pin_a_in,
  // timing engine events
  input wire logic [2:0] stamp_q_overflow_in,
  input wire logic [2:0] stamp_q_nonempty_in,
  input wire logic [1:0] pulse_q_full_in,
  input wire logic [1:0] pulse_seq_done_in,
  input wire logic [1:0] pulse_event_done_in,
  input wire logic [1:0] pulse_event_mark_in,
  input wire logic time_adjust_done_in,
  input wire logic phy_irq_summary_in,
  // configuration and interrupt
  output logic [gtir_pkg::MODE_W-1:0] out_pin_a_mode_out,
  output logic [gtir_pkg::MODE_W-1:0] out_pin_b_mode_out,
  output logic [gtir_pkg::PIN_N*gtir_pkg::MODE_W-1:0] pin_mode_out,
  output logic serial_port_off_out,
  output logic [2:0] serial_cfg_out,
  output logic [1:0] bank_sel_out,
  output logic dev_reset_out,
  output logic timing_irq_out
);
  import gtir_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [PIN_N+1:0] sync_q;
  logic [PIN_N-1:0] pins_s;
  logic strap_s;
  logic out_a_s;
  logic rst_all;
  logic spi_hit, mdio_hit, bank_hit, hit, rd, wr;
  logic [IDX_W-1:0] reg_idx;
  logic [DATA_W-1:0] rd_val;
  logic [MODE_W-1:0] pin1_def;
  logic timing_sum;
  logic [CTRL_A_W-1:0] ctrl_a_reg, ctrl_a_next;
  logic [CTRL_B_W-1:0] ctrl_b_reg, ctrl_b_next;
  logic [BCFG_W-1:0] bank_cfg_reg, bank_cfg_next;
  logic [1:0] page_reg, page_next;
  logic [IRQ_W-1:0] irq_en_reg, irq_en_next;
  logic soft_rst_reg, soft_rst_next;
  logic [PIN_N-1:0] pins_prev_reg, pins_prev_next;
  logic [2:0] ne_prev_reg, ne_prev_next;
  logic [1:0] full_prev_reg, full_prev_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic irq_reg, irq_next;
  logic [PIN_N-1:0] pin_set;
  logic [IRQ_W-1:0] irq_set;

  gtir_evt_if #(.W(PIN_N)) pin_evt ();
  gtir_evt_if #(.W(IRQ_W)) irq_evt ();

  // ----------------------------------------------------------------
  // pin synchronisers and latched flags
  // ----------------------------------------------------------------
  // never reset: straps must reach the defaults while reset is still held
  gtir_sync #(.W(PIN_N + 2), .STAGES(2)) u_sync (
    .clk_in(mclk_in),
    .rst_in(1'b0),
    .ce_in(ce_in),
    .d_in({out_pin_a_in, strap_mode_in, gpio_pin_in}),
    .q_out(sync_q)
  );

  assign pins_s = sync_q[PIN_N-1:0];
  assign strap_s = sync_q[PIN_N];
  assign out_a_s = sync_q[PIN_N+1];
  assign rst_all = reset_in | soft_rst_reg;

  gtir_sticky #(.W(PIN_N)) u_pin_flags (
    .clk_in(mclk_in),
    .rst_in(rst_all),
    .ce_in(ce_in),
    .evt(pin_evt)
  );

  gtir_sticky #(.W(IRQ_W)) u_irq_flags (
    .clk_in(mclk_in),
    .rst_in(rst_all),
    .ce_in(ce_in),
    .evt(irq_evt)
  );

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  always_comb
  begin
    spi_hit = acc_spi_in && !bank_cfg_reg[BCFG_SPIOFF] && (acc_addr_in <= SPI_LAST);
    mdio_hit = !acc_spi_in && bank_cfg_reg[BCFG_SPIOFF] && (page_reg == BANK_TIMING)
      && (acc_addr_in >= MDIO_EXT_BASE) && (acc_addr_in <= MDIO_EXT_LAST);
    bank_hit = !acc_spi_in && (acc_addr_in == MDIO_BANK_ADDR);
    hit = spi_hit || mdio_hit;
    reg_idx = spi_hit ? acc_addr_in[IDX_W-1:0] : IDX_W'(acc_addr_in - MDIO_EXT_BASE);
    rd = acc_valid_in && !acc_write_in;
    wr = acc_valid_in && acc_write_in;
    pin1_def = (!strap_s && out_a_s) ? MODE_CLK125 : MODE_OFF;
    timing_sum = |(irq_evt.q & irq_en_reg);
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < PIN_N; i++)
    begin
      if ((i < LOWER_PINS) ? ctrl_b_reg[EDGE_LO_BIT] : ctrl_b_reg[EDGE_UP_BIT])
        pin_set[i] = pins_s[i] && !pins_prev_reg[i];
      else
        pin_set[i] = !pins_s[i] && pins_prev_reg[i];
    end
    irq_set = {stamp_q_overflow_in[2], stamp_q_nonempty_in[2] && !ne_prev_reg[2],
      stamp_q_overflow_in[1], stamp_q_nonempty_in[1] && !ne_prev_reg[1],
      stamp_q_overflow_in[0], stamp_q_nonempty_in[0] && !ne_prev_reg[0],
      1'b0,
      full_prev_reg[1] && !pulse_q_full_in[1],
      pulse_seq_done_in[1],
      pulse_event_done_in[1] && pulse_event_mark_in[1],
      full_prev_reg[0] && !pulse_q_full_in[0],
      pulse_seq_done_in[0],
      pulse_event_done_in[0] && pulse_event_mark_in[0],
      time_adjust_done_in};
    pin_evt.set = pin_set;
    pin_evt.clr = {PIN_N{rd && hit && (reg_idx == OFF_STATUS)}};
    irq_evt.set = irq_set;
    irq_evt.clr = {IRQ_W{rd && hit && (reg_idx == OFF_IRQ_ST)}};
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_val = '0;
    if (bank_hit)
      rd_val = {1'b0, timing_sum, phy_irq_summary_in, 5'h00, bank_cfg_reg, 2'h0, page_reg};
    else if (hit)
    begin
      unique case (reg_idx)
        OFF_IDENT: rd_val = {SILICON_STEP, PART_CODE};
        OFF_CTRL_A: rd_val = {soft_rst_reg, ctrl_a_reg};
        OFF_CTRL_B: rd_val = {2'h0, ctrl_b_reg};
        OFF_STATUS: rd_val = {1'b0, pin_evt.q, 1'b0, pins_s};
        OFF_IRQ_ST: rd_val = {phy_irq_summary_in, timing_sum, irq_evt.q};
        OFF_IRQ_EN: rd_val = {2'h0, irq_en_reg};
        default: rd_val = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_a_next = ctrl_a_reg;
    ctrl_b_next = ctrl_b_reg;
    bank_cfg_next = bank_cfg_reg;
    page_next = page_reg;
    irq_en_next = irq_en_reg;
    soft_rst_next = soft_rst_reg;
    if (rst_all)
    begin
      ctrl_a_next = {MODE_OUT_RST, MODE_OUT_RST, pin1_def, MODE_OFF, MODE_OFF};
      ctrl_b_next = '0;
      irq_en_next = '0;
      soft_rst_next = 1'b0;
      // the bank page and serial setup sit inside the device reset scope: the hard
      // reset clears them and the soft reset restores them as well
      bank_cfg_next = '0;
      page_next = BANK_PHY;
    end
    else if (ce_in)
    begin
      if (wr && hit && (reg_idx == OFF_CTRL_A))
      begin
        ctrl_a_next = acc_wdata_in[CTRL_A_W-1:0];
        soft_rst_next = acc_wdata_in[CTRL_A_RST_BIT];
      end
      if (wr && hit && (reg_idx == OFF_CTRL_B))
        ctrl_b_next = acc_wdata_in[CTRL_B_W-1:0];
      if (wr && hit && (reg_idx == OFF_IRQ_EN))
        irq_en_next = acc_wdata_in[IRQ_W-1:0];
      if (wr && bank_hit)
      begin
        bank_cfg_next = acc_wdata_in[7:4];
        page_next = acc_wdata_in[1:0];
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    ctrl_a_reg <= ctrl_a_next;
    ctrl_b_reg <= ctrl_b_next;
    bank_cfg_reg <= bank_cfg_next;
    page_reg <= page_next;
    irq_en_reg <= irq_en_next;
    soft_rst_reg <= soft_rst_next;
  end

  // ----------------------------------------------------------------
  // history, answer and interrupt registers
  // ----------------------------------------------------------------
  always_comb
  begin
    pins_prev_next = pins_prev_reg;
    ne_prev_next = ne_prev_reg;
    full_prev_next = full_prev_reg;
    rdata_next = rdata_reg;
    ack_next = ack_reg;
    irq_next = irq_reg;
    if (rst_all)
    begin
      // history follows the inputs so a reset never fakes an edge
      pins_prev_next = pins_s;
      ne_prev_next = stamp_q_nonempty_in;
      full_prev_next = pulse_q_full_in;
      rdata_next = '0;
      ack_next = 1'b0;
      irq_next = 1'b0;
    end
    else if (ce_in)
    begin
      pins_prev_next = pins_s;
      ne_prev_next = stamp_q_nonempty_in;
      full_prev_next = pulse_q_full_in;
      rdata_next = rd ? rd_val : '0;
      ack_next = acc_valid_in;
      irq_next = timing_sum;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    pins_prev_reg <= pins_prev_next;
    ne_prev_reg <= ne_prev_next;
    full_prev_reg <= full_prev_next;
    rdata_reg <= rdata_next;
    ack_reg <= ack_next;
    irq_reg <= irq_next;
  end

  assign rdata_out = rdata_reg;
  assign ack_out = ack_reg;
  assign out_pin_a_mode_out = ctrl_a_reg[14:12];
  assign out_pin_b_mode_out = ctrl_a_reg[11:9];
  assign pin_mode_out = {ctrl_b_reg[11:0], ctrl_a_reg[2:0], ctrl_a_reg[5:3], ctrl_a_reg[8:6]};
  assign serial_port_off_out = bank_cfg_reg[BCFG_SPIOFF];
  assign serial_cfg_out = bank_cfg_reg[3:1];
  assign bank_sel_out = page_reg;
  assign dev_reset_out = soft_rst_reg;
  assign timing_irq_out = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking

  a_spi_gated: assert property (disable iff (rst_all)
    ce_in && rd && acc_spi_in && bank_cfg_reg[BCFG_SPIOFF] |=> rdata_out == '0)
    else $error("spi read answered while serial port off");
  a_bank_reset: assert property (ce_in && reset_in |=> bank_sel_out == BANK_PHY)
    else $error("bank field not cleared by reset");
  a_ident_read: assert property (disable iff (rst_all)
    ce_in && rd && hit && reg_idx == OFF_IDENT |=> rdata_out == {SILICON_STEP, PART_CODE})
    else $error("ident read wrong");
  a_soft_reset: assert property (disable iff (reset_in)
    ce_in && dev_reset_out |=> !dev_reset_out && out_pin_a_mode_out == MODE_OUT_RST
    && irq_en_reg == '0)
    else $error("soft reset did not restore defaults or self clear");
  a_pin1_strap: assert property (ce_in && reset_in && !strap_s && out_a_s
    |=> pin_mode_out[2:0] == MODE_CLK125)
    else $error("pin1 strap default wrong");
  a_pin_latch: assert property (disable iff (rst_all)
    ce_in && pin_set != '0 |=> (pin_evt.q & $past(pin_set)) == $past(pin_set))
    else $error("pin edge not latched");
  a_read_keep: assert property (disable iff (rst_all)
    ce_in && pin_evt.clr[0] |=> pin_evt.q == $past(pin_set))
    else $error("read clear lost an event or kept stale flags");
  a_live_level: assert property (disable iff (rst_all)
    ce_in && rd && hit && reg_idx == OFF_STATUS |=> rdata_out[6:0] == $past(pins_s))
    else $error("live pin level wrong");
  a_irq_summary: assert property (disable iff (rst_all)
    ce_in ##1 ce_in |=> timing_irq_out == $past(timing_sum))
    else $error("timing summary does not follow flags and enables");
  a_mark_event: assert property (disable iff (rst_all)
    ce_in && pulse_event_done_in[0] && !pulse_event_mark_in[0] && !irq_evt.q[1]
    && !irq_evt.clr[0] |=> !irq_evt.q[1])
    else $error("unmarked event latched");
  a_enable_reset: assert property (ce_in && reset_in |=> irq_en_reg == '0 && !timing_irq_out)
    else $error("enables not cleared by reset");

  c_soft_reset: cover property (ce_in && dev_reset_out);
  c_pin_latch: cover property (ce_in && pin_set != '0 && pin_evt.clr[0]);
  c_irq_out: cover property (timing_irq_out ##1 ce_in && irq_evt.clr[0]);
  c_mdio_access: cover property (ce_in && mdio_hit && rd);
endmodule
`default_nettype wire

/* common/gtir_pkg.sv */
// Purpose: shared constants for the pin and timing interrupt register bank
// Assumes: 16-bit registers, 5-bit register addresses from the MDIO/SPI front end
// Notes: timing register indices are shared by SPI and MDIO bank 1
package gtir_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int IDX_W = 3;
  // ----------------------------------------------------------------
  // register indices inside the timing bank
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] OFF_IDENT = 3'h0;
  localparam logic [IDX_W-1:0] OFF_CTRL_A = 3'h1;
  localparam logic [IDX_W-1:0] OFF_CTRL_B = 3'h2;
  localparam logic [IDX_W-1:0] OFF_STATUS = 3'h3;
  localparam logic [IDX_W-1:0] OFF_IRQ_ST = 3'h4;
  localparam logic [IDX_W-1:0] OFF_IRQ_EN = 3'h5;
  // ----------------------------------------------------------------
  // address windows
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SPI_LAST = 5'h05;
  localparam logic [ADDR_W-1:0] MDIO_EXT_BASE = 5'h10;
  localparam logic [ADDR_W-1:0] MDIO_EXT_LAST = 5'h15;
  localparam logic [ADDR_W-1:0] MDIO_BANK_ADDR = 5'h1F;
  localparam logic [1:0] BANK_PHY = 2'h0;
  localparam logic [1:0] BANK_TIMING = 2'h1;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_A_W = 15;
  localparam int CTRL_A_RST_BIT = 15;
  localparam int CTRL_B_W = 14;
  localparam int EDGE_UP_BIT = 13;
  localparam int EDGE_LO_BIT = 12;
  localparam int MODE_W = 3;
  localparam int PIN_N = 7;
  localparam int LOWER_PINS = 3;
  localparam int IRQ_W = 14;
  localparam int BCFG_W = 4;
  localparam int BCFG_SPIOFF = 0;
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_CLK125 = 3'h4;
  localparam logic [MODE_W-1:0] MODE_OUT_RST = 3'h6;
endpackage

/* common/gtir_evt_if.sv */
// Purpose: event set/clear bundle between the bank and its sticky bits
// Assumes: one clock domain
// Notes: q is the held flag vector
`timescale 1ns/1ps
`default_nettype none
interface gtir_evt_if #(parameter int W = 1);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport src (output set, output clr, input q);
  modport bank (input set, input clr, output q);
endinterface
`default_nettype wire

/* src/gtir_sync.sv */
// Purpose: multi-bit two-stage synchroniser for pin inputs
// Assumes: bits are independent levels
// Notes: only the last stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module gtir_sync #(
  parameter int W = 1,
  parameter int STAGES = 2
)(
  // clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] st_reg [STAGES];
  logic [W-1:0] st_next [STAGES];

  if (STAGES < 2) $error("gtir_sync needs at least two stages");

  always_comb
  begin
    st_next = st_reg;
    if (rst_in)
    begin
      for (int i = 0; i < STAGES; i++)
        st_next[i] = '0;
    end
    else if (ce_in)
    begin
      st_next[0] = d_in;
      for (int i = 1; i < STAGES; i++)
        st_next[i] = st_reg[i-1];
    end
  end

  always_ff @(posedge clk_in)
  begin
    st_reg <= st_next;
  end

  assign q_out = st_reg[STAGES-1];
endmodule
`default_nettype wire

/* src/gtir_sticky.sv */
// Purpose: latched status flags, set by events, cleared on read
// Assumes: clear and set arrive in the same clock domain
// Notes: a set in the clearing cycle survives
`timescale 1ns/1ps
`default_nettype none
module gtir_sticky #(
  parameter int W = 1
)(
  // clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // flags
  gtir_evt_if.bank evt
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  if (W < 1) $error("gtir_sticky width must be positive");

  always_comb
  begin
    q_next = q_reg;
    if (rst_in)
      q_next = '0;
    else if (ce_in)
      q_next = (q_reg & ~evt.clr) | evt.set;
  end

  always_ff @(posedge clk_in)
  begin
    q_reg <= q_next;
  end

  assign evt.q = q_reg;
endmodule
`default_nettype wire

/* bench/gtir_mgmt_model.sv */
// Purpose: management controller model issuing single register accesses
// Assumes: one access per taken edge, answer stands in the cycle after it
// Notes: idle address and data lines are inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module gtir_mgmt_model (
  // clock
  input wire logic clk_in,
  // access request
  output logic valid_out,
  output logic write_out,
  output logic spi_out,
  output logic [gtir_pkg::ADDR_W-1:0] addr_out,
  output logic [gtir_pkg::DATA_W-1:0] wdata_out,
  // answer
  input wire logic ack_in,
  input wire logic [gtir_pkg::DATA_W-1:0] rdata_in
);
  import gtir_pkg::*;
  initial
  begin
    valid_out = 1'b0;
    write_out = 1'b0;
    spi_out = 1'b0;
    addr_out = 5'h00;
    wdata_out = 16'h0000;
  end
  // ----------------------------------------------------------------
  // one access: valid high over exactly one edge, so reads clear once
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic spi, input logic [ADDR_W-1:0] addr,
    input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic acked);
    @(posedge clk_in);
    valid_out <= 1'b1;
    write_out <= wr;
    spi_out <= spi;
    addr_out <= addr;
    wdata_out <= wd;
    @(posedge clk_in);
    valid_out <= 1'b0;
    addr_out <= ~addr;
    wdata_out <= ~wd;
    @(posedge clk_in);
    acked = ack_in;
    rd = rdata_in;
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Purpose: self-checking bench for the pin and timing interrupt register bank
// Assumes: straps settle before reset is released
// Notes: expected values are built from the register layout by hand
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import gtir_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ce_in = 1'b1;
  logic acc_valid_in, acc_write_in, acc_spi_in;
  logic [ADDR_W-1:0] acc_addr_in;
  logic [DATA_W-1:0] acc_wdata_in, rdata_out;
  logic ack_out, strap_mode_in = 1'b0, out_pin_a_in = 1'b1;
  logic [PIN_N-1:0] gpio_pin_in = 7'h00;
  logic [2:0] stamp_q_overflow_in = 3'h0, stamp_q_nonempty_in = 3'h0;
  logic [1:0] pulse_q_full_in = 2'h3, pulse_seq_done_in = 2'h0;
  logic [1:0] pulse_event_done_in = 2'h0, pulse_event_mark_in = 2'h0;
  logic time_adjust_done_in = 1'b0, phy_irq_summary_in = 1'b0;
  logic [MODE_W-1:0] out_pin_a_mode_out, out_pin_b_mode_out;
  logic [PIN_N*MODE_W-1:0] pin_mode_out;
  logic serial_port_off_out, dev_reset_out, timing_irq_out;
  logic [2:0] serial_cfg_out;
  logic [1:0] bank_sel_out;
  int n_fail = 0;
  int n_tests = 0;
  always #20 mclk_in = ~mclk_in;
  gtir_top #(.SILICON_STEP(4'h1), .PART_CODE(12'h5A3)) dut (.mclk_in(mclk_in),
    .reset_in(reset_in), .ce_in(ce_in),
    .acc_valid_in(acc_valid_in), .acc_write_in(acc_write_in), .acc_spi_in(acc_spi_in),
    .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in), .rdata_out(rdata_out),
    .ack_out(ack_out), .gpio_pin_in(gpio_pin_in), .strap_mode_in(strap_mode_in),
    .out_pin_a_in(out_pin_a_in), .stamp_q_overflow_in(stamp_q_overflow_in),
    .stamp_q_nonempty_in(stamp_q_nonempty_in), .pulse_q_full_in(pulse_q_full_in),
    .pulse_seq_done_in(pulse_seq_done_in), .pulse_event_done_in(pulse_event_done_in),
    .pulse_event_mark_in(pulse_event_mark_in), .time_adjust_done_in(time_adjust_done_in),
    .phy_irq_summary_in(phy_irq_summary_in), .out_pin_a_mode_out(out_pin_a_mode_out),
    .out_pin_b_mode_out(out_pin_b_mode_out), .pin_mode_out(pin_mode_out),
    .serial_port_off_out(serial_port_off_out), .serial_cfg_out(serial_cfg_out),
    .bank_sel_out(bank_sel_out), .dev_reset_out(dev_reset_out),
    .timing_irq_out(timing_irq_out));
  gtir_mgmt_model host (.clk_in(mclk_in), .valid_out(acc_valid_in),
    .write_out(acc_write_in), .spi_out(acc_spi_in), .addr_out(acc_addr_in),
    .wdata_out(acc_wdata_in), .ack_in(ack_out), .rdata_in(rdata_out));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic spi, input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic k;
    host.access(1'b0, spi, a, 16'h0000, d, k);
    check({15'h0000, k}, 16'h0001);
    check(d, exp);
  endtask
  task automatic wr(input logic spi, input logic [4:0] a, input logic [15:0] v);
    logic [15:0] d;
    logic k;
    host.access(1'b1, spi, a, v, d, k);
    check({15'h0000, k}, 16'h0001);
  endtask
  task automatic strobe(input logic [2:0] ovf, input logic [1:0] seq, input logic [1:0] evt,
    input logic [1:0] mark, input logic tadj);
    @(posedge mclk_in);
    stamp_q_overflow_in <= ovf;
    pulse_seq_done_in <= seq;
    pulse_event_done_in <= evt;
    pulse_event_mark_in <= mark;
    time_adjust_done_in <= tadj;
    @(posedge mclk_in);
    stamp_q_overflow_in <= 3'h0;
    pulse_seq_done_in <= 2'h0;
    pulse_event_done_in <= 2'h0;
    pulse_event_mark_in <= 2'h0;
    time_adjust_done_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
  endtask
  // ----------------------------------------------------------------
  // watchdog: whole sequence needs well under 1000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3000) @(posedge mclk_in);
    n_fail++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(1'b1, 5'h00, 16'h15A3);
    wr(1'b1, 5'h00, 16'hFFFF);
    rd(1'b1, 5'h00, 16'h15A3);
    rd(1'b1, 5'h01, 16'h6D00);
    rd(1'b1, 5'h02, 16'h0000);
    rd(1'b1, 5'h05, 16'h0000);
    rd(1'b1, 5'h06, 16'h0000);
    rd(1'b0, MDIO_BANK_ADDR, 16'h0000);
    rd(1'b0, 5'h10, 16'h0000);
    check({10'h000, out_pin_a_mode_out, out_pin_b_mode_out}, 16'h0036);
    check({13'h0000, pin_mode_out[2:0]}, 16'h0004);
    // bank select moves the timing registers from the serial port to MDIO
    wr(1'b0, MDIO_BANK_ADDR, 16'h00F1);
    check({10'h000, serial_cfg_out, serial_port_off_out, bank_sel_out}, 16'h003D);
    rd(1'b0, MDIO_BANK_ADDR, 16'h00F1);
    rd(1'b0, 5'h10, 16'h15A3);
    rd(1'b1, 5'h00, 16'h0000);
    wr(1'b0, MDIO_BANK_ADDR, 16'h0000);
    rd(1'b0, 5'h10, 16'h0000);
    rd(1'b1, 5'h00, 16'h15A3);
    // pin edges: upper pins rising, lower pins falling
    wr(1'b1, 5'h02, 16'h2FFF);
    rd(1'b1, 5'h02, 16'h2FFF);
    check({4'h0, pin_mode_out[20:9]}, 16'h0FFF);
    @(posedge mclk_in);
    gpio_pin_in <= 7'h7F;
    repeat (6) @(posedge mclk_in);
    rd(1'b1, 5'h03, 16'h787F);
    rd(1'b1, 5'h03, 16'h007F);
    gpio_pin_in <= 7'h00;
    repeat (6) @(posedge mclk_in);
    rd(1'b1, 5'h03, 16'h0700);
    wr(1'b1, 5'h02, 16'h1000);
    gpio_pin_in <= 7'h7F;
    repeat (6) @(posedge mclk_in);
    rd(1'b1, 5'h03, 16'h077F);
    // timing flags: an unmarked event must not latch
    phy_irq_summary_in <= 1'b1;
    strobe(3'h0, 2'h0, 2'h3, 2'h0, 1'b0);
    rd(1'b1, 5'h04, 16'h8000);
    stamp_q_nonempty_in <= 3'h7;
    pulse_q_full_in <= 2'h0;
    strobe(3'h7, 2'h3, 2'h3, 2'h3, 1'b1);
    rd(1'b1, 5'h04, 16'hBF7F);
    rd(1'b1, 5'h04, 16'h8000);
    // enables gate the summary and the interrupt output
    wr(1'b1, 5'h05, 16'hFFFF);
    rd(1'b1, 5'h05, 16'h3FFF);
    wr(1'b1, 5'h05, 16'h0001);
    strobe(3'h0, 2'h0, 2'h0, 2'h0, 1'b1);
    check({15'h0000, timing_irq_out}, 16'h0001);
    rd(1'b0, MDIO_BANK_ADDR, 16'h6000);
    rd(1'b1, 5'h04, 16'hC001);
    repeat (2) @(posedge mclk_in);
    check({15'h0000, timing_irq_out}, 16'h0000);
    strobe(3'h0, 2'h1, 2'h0, 2'h0, 1'b0);
    check({15'h0000, timing_irq_out}, 16'h0000);
    rd(1'b1, 5'h04, 16'h8004);
    // enable low freezes the bank: a pulse meanwhile is not seen
    ce_in <= 1'b0;
    strobe(3'h0, 2'h0, 2'h0, 2'h0, 1'b1);
    ce_in <= 1'b1;
    rd(1'b1, 5'h04, 16'h8000);
    // soft reset restores defaults with the strap sampled again
    wr(1'b1, 5'h01, 16'h0000);
    rd(1'b1, 5'h01, 16'h0000);
    strap_mode_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    wr(1'b1, 5'h01, 16'h8000);
    check({15'h0000, dev_reset_out}, 16'h0001);
    @(posedge mclk_in);
    check({15'h0000, dev_reset_out}, 16'h0000);
    repeat (3) @(posedge mclk_in);
    rd(1'b1, 5'h01, 16'h6C00);
    rd(1'b1, 5'h05, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
